//--- shared/led_blink_defs.svh
// register indices, field positions, reset values and timing figures of the lamp block
`ifndef LED_BLINK_DEFS_SVH
`define LED_BLINK_DEFS_SVH

// register indices: byte address is four times the index
`define LAMP0_CFG_INDEX 32'h0000_40C0
`define SHARED_CTRL_INDEX 32'h0000_40C1
`define BLINK_RATE_INDEX 32'h0000_40C2
`define LAMP1_CFG_INDEX 32'h0000_40C3
`define LAMP_STATUS_INDEX 32'h0000_40CF

// reset values
`define LAMP0_CFG_RESET 16'h0311
`define LAMP1_CFG_RESET 16'h0310
`define SHARED_CTRL_RESET 16'h00CC
`define BLINK_RATE_RESET 16'hEC75

// writable masks (reserved bits read as zero)
`define SHARED_CTRL_MASK 16'h03FF
`define LAMP1_CFG_MASK 16'hFFFE

// shared control fields
`define DUTY_INVERT_BIT 9
`define LOOPBACK_SUPPRESS_BIT 8
`define JABBER_SUPPRESS_BIT 7
`define COLLISION_SELECT_BIT 6
`define WEIGHT_ENABLE_BIT 5
`define THRESHOLD_MSB 4
`define THRESHOLD_LSB 0

// blink rate fields
`define MODE0_RATE_LSB 12
`define MODE1_RATE_LSB 8
`define MODE2_RATE_LSB 4

// per-lamp configuration fields
`define FORCE_ENABLE_BIT 15
`define FORCE_CODE_MSB 14
`define FORCE_CODE_LSB 13
`define TX_BLINK_ENABLE_BIT 9
`define RX_BLINK_ENABLE_BIT 8
`define COLLISION_BLINK_ENABLE_BIT 3

// timing
`define CLOCK_MHZ 40
`define TRAFFIC_WINDOW_US 1000000
`define THRESHOLD_UNIT_US 42000

`endif

//--- shared/led_blink_pkg.sv
// types shared by the lamp pattern block
package led_blink_pkg;

    typedef enum logic [1:0] {
        BLINK_MODE0,
        BLINK_MODE1,
        BLINK_MODE2
    } blink_mode_t;

    // link events seen by the lamp logic
    typedef struct packed {
        logic link_up;
        logic transmit_active;
        logic receive_active;
        logic collision;
        logic loopback_active;
        logic jabber;
    } phy_event_t;

    // fields of one lamp's configuration word
    typedef struct packed {
        logic force_enable;
        logic [1:0] lamp_force_code;
        logic transmit_activity_blink_enable;
        logic receive_activity_blink_enable;
        logic collision_blink_enable;
    } lamp_cfg_t;

    // AHB-Lite slave-side inputs
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } ahb_req_t;

endpackage

//--- hw/led_blink_pattern_control.sv
// lamp blink pattern, traffic weight and register logic with an AHB-Lite slave
`include "led_blink_defs.svh"

module led_blink_pattern_control #(
    parameter int CYCLES_PER_US = `CLOCK_MHZ,
    parameter int WINDOW_CYCLES = `TRAFFIC_WINDOW_US * `CLOCK_MHZ,
    parameter int THRESHOLD_UNIT_CYCLES = `THRESHOLD_UNIT_US * `CLOCK_MHZ,
    parameter int LAMPS = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire led_blink_pkg::ahb_req_t bus,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire led_blink_pkg::phy_event_t phy,
    output logic [LAMPS-1:0] lamp
);
    import led_blink_pkg::*;

    logic [15:0] shared_ctrl;
    logic [15:0] blink_rate;
    logic [15:0] lamp_cfg_word [LAMPS];
    lamp_cfg_t lamp_cfg [LAMPS];
    logic write_pending;
    logic [31:0] write_addr;
    logic [31:0] window_count;
    logic [31:0] rx_accum;
    logic [31:0] tx_accum;
    logic heavy_rx;
    logic heavy_tx;
    logic heavy;
    logic [31:0] threshold_cycles;
    logic window_end;
    logic [31:0] blink_count [3];
    logic [31:0] period_cycles [3];
    logic [31:0] off_cycles [3];
    logic [2:0] wave;
    logic suppress;
    logic lamp_blink [LAMPS];
    logic lamp_steady [LAMPS];
    blink_mode_t lamp_mode [LAMPS];
    logic [31:0] next_rdata;
    logic address_valid;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait states, stalled only while the clock enable is low

    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign address_valid = bus.hsel && bus.htrans[1] && bus.hready;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            write_pending <= 1'b0;
            write_addr <= 32'h0000_0000;
        end
        else if (ce)
        begin
            write_pending <= address_valid && bus.hwrite;
            write_addr <= bus.haddr;
        end
    end

    // a read in the data phase of a write to the same register sees the old value
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shared_ctrl <= `SHARED_CTRL_RESET;
            blink_rate <= `BLINK_RATE_RESET;
            lamp_cfg_word[0] <= `LAMP0_CFG_RESET;
            lamp_cfg_word[1] <= `LAMP1_CFG_RESET;
        end
        else if (ce && write_pending)
        begin
            case (write_addr)
                `SHARED_CTRL_INDEX << 2:
                    shared_ctrl <= bus.hwdata[15:0] & `SHARED_CTRL_MASK;
                `BLINK_RATE_INDEX << 2:
                    blink_rate <= bus.hwdata[15:0];
                `LAMP0_CFG_INDEX << 2:
                    lamp_cfg_word[0] <= bus.hwdata[15:0];
                `LAMP1_CFG_INDEX << 2:
                    lamp_cfg_word[1] <= bus.hwdata[15:0] & `LAMP1_CFG_MASK;
                default:
                    ;
            endcase
        end
    end

    // read data is captured in the address phase and stands in the data phase
    always_comb
    begin
        case (bus.haddr)
            `SHARED_CTRL_INDEX << 2:
                next_rdata = {16'h0000, shared_ctrl};
            `BLINK_RATE_INDEX << 2:
                next_rdata = {16'h0000, blink_rate};
            `LAMP0_CFG_INDEX << 2:
                next_rdata = {16'h0000, lamp_cfg_word[0]};
            `LAMP1_CFG_INDEX << 2:
                next_rdata = {16'h0000, lamp_cfg_word[1]};
            `LAMP_STATUS_INDEX << 2:
                next_rdata = {27'h0000000, lamp[1], lamp[0], heavy, heavy_tx, heavy_rx};
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (ce && address_valid && !bus.hwrite)
            hrdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // traffic weight over one-second windows

    assign threshold_cycles = 32'(shared_ctrl[`THRESHOLD_MSB:`THRESHOLD_LSB])
        * 32'(THRESHOLD_UNIT_CYCLES);
    assign window_end = (window_count == 32'(WINDOW_CYCLES - 1));
    assign heavy = heavy_rx || heavy_tx;
    // activity in the closing cycle of a window is dropped with the cleared totals

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            window_count <= 32'h0000_0000;
            rx_accum <= 32'h0000_0000;
            tx_accum <= 32'h0000_0000;
            heavy_rx <= 1'b0;
            heavy_tx <= 1'b0;
        end
        else if (ce)
        begin
            if (window_end)
            begin
                window_count <= 32'h0000_0000;
                rx_accum <= 32'h0000_0000;
                tx_accum <= 32'h0000_0000;
                heavy_rx <= rx_accum > threshold_cycles;
                heavy_tx <= tx_accum > threshold_cycles;
            end
            else
            begin
                window_count <= window_count + 32'h0000_0001;
                rx_accum <= rx_accum + 32'(phy.receive_active);
                tx_accum <= tx_accum + 32'(phy.transmit_active);
            end
        end
    end

    sequence window_closes;
        window_end && ce;
    endsequence

    a_heavy_traffic_judge: assert property (window_closes |=>
        heavy_rx == ($past(rx_accum) > $past(threshold_cycles))
        && heavy_tx == ($past(tx_accum) > $past(threshold_cycles)))
        else $error("heavy traffic flags disagree with the window totals");

    ////////////////////////////////////////////////////////////////////////////////
    // rate table in microseconds: period and off time per code

    function automatic logic [47:0] rate_entry(input logic [3:0] code);
        case (code)
            4'h0: rate_entry = {24'd10000000, 24'd600000};
            4'h1: rate_entry = {24'd9400000, 24'd658000};
            4'h2: rate_entry = {24'd8000000, 24'd640000};
            4'h3: rate_entry = {24'd7400000, 24'd666000};
            4'h4: rate_entry = {24'd6000000, 24'd660000};
            4'h5: rate_entry = {24'd5000000, 24'd300000};
            4'h6: rate_entry = {24'd4000000, 24'd320000};
            4'h7: rate_entry = {24'd3000000, 24'd330000};
            4'h8: rate_entry = {24'd2000000, 24'd320000};
            4'h9: rate_entry = {24'd1000000, 24'd160000};
            4'hA: rate_entry = {24'd500000, 24'd250000};
            4'hC: rate_entry = {24'd333333, 24'd166667};
            4'hD: rate_entry = {24'd166667, 24'd83333};
            4'hE: rate_entry = {24'd125000, 24'd62500};
            4'hF: rate_entry = {24'd100000, 24'd50000};
            // code 11 has no meaning of its own and falls back to 2 Hz
            default: rate_entry = {24'd500000, 24'd250000};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // one free-running waveform per blink mode

    for (genvar m = 0; m < 3; m++)
    begin : g_mode
        logic [3:0] code;
        logic [47:0] entry;
        logic raw;

        // mode 0 at 15:12, mode 1 at 11:8, mode 2 at 7:4
        assign code = (m == 0) ? blink_rate[`MODE0_RATE_LSB +: 4] :
            (m == 1) ? blink_rate[`MODE1_RATE_LSB +: 4] :
            blink_rate[`MODE2_RATE_LSB +: 4];
        assign entry = rate_entry(code);
        assign period_cycles[m] = 32'(entry[47:24]) * 32'(CYCLES_PER_US);
        assign off_cycles[m] = 32'(entry[23:0]) * 32'(CYCLES_PER_US);

        always_ff @(posedge clk)
        begin
            if (rst)
                blink_count[m] <= 32'h0000_0000;
            else if (ce)
            begin
                if (blink_count[m] >= period_cycles[m] - 32'h0000_0001)
                    blink_count[m] <= 32'h0000_0000;
                else
                    blink_count[m] <= blink_count[m] + 32'h0000_0001;
            end
        end

        // off portion opens the period, on portion closes it
        assign raw = blink_count[m] >= off_cycles[m];
        assign wave[m] = shared_ctrl[`DUTY_INVERT_BIT] ? !raw : raw;

        a_duty_swap: assert property (shared_ctrl[`DUTY_INVERT_BIT]
            && blink_count[m] < off_cycles[m] |-> wave[m])
            else $error("inverted duty does not light the off share");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-lamp source selection and the lamp flip-flops

    assign suppress = (shared_ctrl[`LOOPBACK_SUPPRESS_BIT] && phy.loopback_active)
        || (shared_ctrl[`JABBER_SUPPRESS_BIT] && phy.jabber);

    for (genvar i = 0; i < LAMPS; i++)
    begin : g_lamp
        logic activity;

        assign lamp_cfg[i] = '{
            force_enable: lamp_cfg_word[i][`FORCE_ENABLE_BIT],
            lamp_force_code: lamp_cfg_word[i][`FORCE_CODE_MSB:`FORCE_CODE_LSB],
            transmit_activity_blink_enable: lamp_cfg_word[i][`TX_BLINK_ENABLE_BIT],
            receive_activity_blink_enable: lamp_cfg_word[i][`RX_BLINK_ENABLE_BIT],
            collision_blink_enable: lamp_cfg_word[i][`COLLISION_BLINK_ENABLE_BIT]
        };
        assign activity = phy.link_up
            && ((phy.transmit_active && lamp_cfg[i].transmit_activity_blink_enable)
            || (phy.receive_active && lamp_cfg[i].receive_activity_blink_enable));

        always_comb
        begin
            lamp_blink[i] = 1'b0;
            lamp_steady[i] = 1'b0;
            lamp_mode[i] = BLINK_MODE1;
            if (lamp_cfg[i].force_enable)
            begin
                case (lamp_cfg[i].lamp_force_code)
                    2'b11:
                    begin
                        lamp_blink[i] = 1'b1;
                        lamp_mode[i] = BLINK_MODE2;
                    end
                    2'b10:
                        lamp_blink[i] = 1'b1;
                    2'b01:
                        lamp_steady[i] = 1'b1;
                    default:
                        lamp_steady[i] = 1'b0;
                endcase
            end
            else if (suppress)
                lamp_blink[i] = 1'b0;
            else if (phy.link_up && phy.collision && lamp_cfg[i].collision_blink_enable)
            begin
                lamp_blink[i] = 1'b1;
                lamp_mode[i] = shared_ctrl[`COLLISION_SELECT_BIT] ? BLINK_MODE2
                    : BLINK_MODE1;
            end
            else if (activity)
            begin
                lamp_blink[i] = 1'b1;
                lamp_mode[i] = (shared_ctrl[`WEIGHT_ENABLE_BIT] && heavy) ? BLINK_MODE0
                    : BLINK_MODE1;
            end
        end

        always_ff @(posedge clk)
        begin
            if (rst)
                lamp[i] <= 1'b0;
            else if (ce)
                lamp[i] <= lamp_blink[i] ? wave[lamp_mode[i]] : lamp_steady[i];
        end

        sequence collision_event;
            !lamp_cfg[i].force_enable && !suppress && phy.link_up && phy.collision
                && lamp_cfg[i].collision_blink_enable;
        endsequence

        // no event that may light the lamp is both present and enabled
        sequence quiet_event;
            !lamp_cfg[i].force_enable && !activity
                && !(phy.collision && lamp_cfg[i].collision_blink_enable);
        endsequence

        a_col_mode_two: assert property (collision_event
            and shared_ctrl[`COLLISION_SELECT_BIT] |-> lamp_blink[i]
            && lamp_mode[i] == BLINK_MODE2)
            else $error("collision did not select mode 2");
        a_col_mode_one: assert property (collision_event
            and !shared_ctrl[`COLLISION_SELECT_BIT] |-> lamp_blink[i]
            && lamp_mode[i] == BLINK_MODE1)
            else $error("collision did not select mode 1");
        a_col_needs_enable: assert property (quiet_event ##1 (quiet_event and ce)
            |=> !lamp[i])
            else $error("lamp blinked with no enabled event");
        a_loopback_quiet: assert property (!lamp_cfg[i].force_enable
            && shared_ctrl[`LOOPBACK_SUPPRESS_BIT] && phy.loopback_active
            |-> !lamp_blink[i])
            else $error("lamp blinked during suppressed loopback");
        a_jabber_quiet: assert property (!lamp_cfg[i].force_enable
            && shared_ctrl[`JABBER_SUPPRESS_BIT] && phy.jabber |-> !lamp_blink[i])
            else $error("lamp blinked during suppressed jabber");
        a_heavy_mode_zero: assert property (!lamp_cfg[i].force_enable && !suppress
            && !(phy.link_up && phy.collision && lamp_cfg[i].collision_blink_enable)
            && activity && shared_ctrl[`WEIGHT_ENABLE_BIT] && heavy
            |-> lamp_mode[i] == BLINK_MODE0)
            else $error("heavy traffic did not select mode 0");
        a_light_mode_one: assert property (!lamp_cfg[i].force_enable && !suppress
            && !(phy.link_up && phy.collision && lamp_cfg[i].collision_blink_enable)
            && activity && !shared_ctrl[`WEIGHT_ENABLE_BIT]
            |-> lamp_blink[i] && lamp_mode[i] == BLINK_MODE1)
            else $error("activity with weighting off did not select mode 1");
        a_force_steady: assert property (ce && lamp_cfg[i].force_enable
            && lamp_cfg[i].lamp_force_code[1] == 1'b0
            |=> lamp[i] == $past(lamp_cfg[i].lamp_force_code[0]))
            else $error("forced steady level not shown on the lamp");
    end

endmodule // led_blink_pattern_control

//--- tb/led_lamp_model.sv
// indicator lamps as seen by an observer on the lamp pins
module led_lamp_model #(
    parameter int LAMPS = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [LAMPS-1:0] lamp,
    output logic [LAMPS-1:0] glow
);
    timeunit 1ns;
    timeprecision 1ps;
    // a lamp shows the pin level latched at each edge, dark in reset
    always_ff @(posedge clk)
    begin
        if (rst)
            glow <= '0;
        else
            glow <= lamp;
    end
endmodule // led_lamp_model

//--- tb/tb_led_blink_pattern_control.sv
// self-checking bench for the lamp pattern block
`include "led_blink_defs.svh"

module tb_led_blink_pattern_control;
    import led_blink_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic link_up = 1'b0;
    logic tx = 1'b0;
    logic rx = 1'b0;
    logic col = 1'b0;
    logic lpbk = 1'b0;
    logic jab = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [1:0] lamp;
    logic [1:0] glow;
    wire ahb_req_t bus;
    wire phy_event_t phy;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    assign bus = {hsel, haddr, htrans, hwrite, 3'b010, hreadyout, hwdata};
    assign phy = {link_up, tx, rx, col, lpbk, jab};

    led_blink_pattern_control #(
        .CYCLES_PER_US(1),
        .WINDOW_CYCLES(1000),
        .THRESHOLD_UNIT_CYCLES(10),
        .LAMPS(2)
    ) led_blink_pattern_control_inst (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .bus(bus),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .phy(phy),
        .lamp(lamp)
    );

    led_lamp_model #(.LAMPS(2)) led_lamp_model_inst (
        .clk(clk),
        .rst(rst),
        .lamp(lamp),
        .glow(glow)
    );

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (!rst)
            cyc <= cyc + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // one single AHB transfer; returns read data taken at the data phase edge
    task automatic xfer(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd_data);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= idx << 2;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_data = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] idx, input logic [15:0] d);
        logic [31:0] dummy;
        xfer(1'b1, idx, {16'hFFFF, d}, dummy);
    endtask

    task automatic rd(input logic [31:0] idx, input logic [15:0] exp);
        logic [31:0] v;
        xfer(1'b0, idx, 32'h0, v);
        check(v, {16'h0, exp});
    endtask

    // lamp level after the pipeline and the observer have settled
    task automatic see(input logic [1:0] exp);
        repeat (5) @(posedge clk);
        check({30'h0, glow}, {30'h0, exp});
    endtask

    task automatic wait_cyc(input int n);
        while (cyc < n) @(posedge clk);
    endtask

    task automatic wait_mod(input int m);
        do @(posedge clk); while (cyc % 1000 != m);
    endtask

    // activity for nr and nt cycles inside one window, status read in the next
    task automatic traffic(input int nr, input int nt, input logic [15:0] exp);
        wait_mod(200);
        for (int i = 0; i <= ((nr > nt) ? nr : nt); i++)
        begin
            rx <= (i < nr);
            tx <= (i < nt);
            @(posedge clk);
        end
        wait_mod(900);
        wait_mod(100);
        rd(`LAMP_STATUS_INDEX, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int tab [4][3] = '{'{51, 0, 5}, '{50, 0, 0}, '{0, 51, 6}, '{30, 30, 0}};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`LAMP0_CFG_INDEX, 16'h0311);
        rd(`SHARED_CTRL_INDEX, 16'h00CC);
        rd(`BLINK_RATE_INDEX, 16'hEC75);
        rd(`LAMP1_CFG_INDEX, 16'h0310);
        rd(`LAMP_STATUS_INDEX, 16'h0000);
        rd(32'h0000_40CE, 16'h0000);
        wr(`SHARED_CTRL_INDEX, 16'hFFFF);
        rd(`SHARED_CTRL_INDEX, 16'h03FF);
        wr(`LAMP1_CFG_INDEX, 16'hFFFF);
        rd(`LAMP1_CFG_INDEX, 16'hFFFE);
        wr(`SHARED_CTRL_INDEX, 16'h00CC);
        wr(`BLINK_RATE_INDEX, 16'hECF5);
        rd(`BLINK_RATE_INDEX, 16'hECF5);
        // early in every period all blink modes are in their off share
        wr(`LAMP1_CFG_INDEX, 16'h8000);
        wr(`LAMP0_CFG_INDEX, 16'hA000);
        see(2'b01);
        wr(`LAMP0_CFG_INDEX, 16'h8000);
        see(2'b00);
        wr(`LAMP0_CFG_INDEX, 16'hE000);
        see(2'b00);
        wr(`SHARED_CTRL_INDEX, 16'h02CC);
        see(2'b01);
        wr(`LAMP0_CFG_INDEX, 16'hC000);
        see(2'b01);
        wr(`LAMP0_CFG_INDEX, 16'h0300);
        link_up <= 1'b1;
        tx <= 1'b1;
        see(2'b01);
        jab <= 1'b1;
        see(2'b00);
        wr(`SHARED_CTRL_INDEX, 16'h024C);
        see(2'b01);
        wr(`SHARED_CTRL_INDEX, 16'h034C);
        lpbk <= 1'b1;
        see(2'b00);
        wr(`SHARED_CTRL_INDEX, 16'h024C);
        see(2'b01);
        jab <= 1'b0;
        lpbk <= 1'b0;
        tx <= 1'b0;
        see(2'b00);
        wr(`LAMP0_CFG_INDEX, 16'h0000);
        wr(`LAMP1_CFG_INDEX, 16'h0008);
        col <= 1'b1;
        see(2'b10);
        link_up <= 1'b0;
        see(2'b00);
        col <= 1'b0;
        wr(`LAMP0_CFG_INDEX, 16'h8000);
        wr(`LAMP1_CFG_INDEX, 16'h8000);
        wr(`SHARED_CTRL_INDEX, 16'h0005);
        foreach (tab[i])
            traffic(tab[i][0], tab[i][1], tab[i][2][15:0]);
        // mode 2 at code 15 lights from 50000, mode 1 at code 12 stays dark
        wr(`LAMP1_CFG_INDEX, 16'h0008);
        wr(`LAMP0_CFG_INDEX, 16'h0200);
        wr(`SHARED_CTRL_INDEX, 16'h0040);
        link_up <= 1'b1;
        col <= 1'b1;
        wait_cyc(55000);
        see(2'b10);
        wr(`BLINK_RATE_INDEX, 16'hECD5);
        see(2'b00);
        wr(`SHARED_CTRL_INDEX, 16'h0000);
        see(2'b00);
        // mode 0 at code 14 lights from 62500 once traffic is heavy
        tx <= 1'b1;
        wr(`SHARED_CTRL_INDEX, 16'h0020);
        wait_cyc(63000);
        see(2'b01);
        wr(`SHARED_CTRL_INDEX, 16'h0000);
        see(2'b00);
        end_of_test();
    end

    initial
    begin
        repeat (70000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule // tb_led_blink_pattern_control
